// [hw/stream_data_ports.sv]
`timescale 1ns/1ps
`include "stream_port_cfg.svh"
// Function
// - Bidirectional byte bus, bit 7 MSB
// - Two independent identical ports
// - Three-bit address selects internal buffer
// - Single-stream mode ignores buffer address
// - Transfers timed to rising port clock
// - Sustain 27 MB/s in byte mode
// - Device drives sync on receive
// - Sync polarity programmable, default high
// - Default configuration leaves sync unused
// - Read/write polarity programmable, high read
// - Available flags full packet, programmable
// - Reset is active low
// - Enable qualifies transfers, programmable polarity

// ----------------------------------------------------------------
// One port engine: buffers, pin sampling and bus slave data
// ----------------------------------------------------------------
module stream_port_engine
    import stream_port_pkg::*;
#(
    parameter int NBUF = `BUF_COUNT,
    parameter int DEPTH = `BUF_DEPTH
) (
    input wire logic clk, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire port_ctrl_t ctrl, // Port configuration
    input wire logic port_clock, // Host port clock pin
    input wire logic [7:0] data_in, // Data bus input
    input wire logic [2:0] buffer_select, // Buffer address pins
    input wire logic read_write, // Read/write pin
    input wire logic access_enable, // Access enable pin
    input wire logic sync_in, // Sync pin input
    input wire logic rx_push, // Load one receive byte
    input wire logic [7:0] rx_byte, // Receive byte value
    input wire logic [2:0] rx_buf, // Receive buffer target
    input wire logic rx_last, // Last byte of packet
    output port_pins_out_t pins, // Pin drive group
    output logic [7:0] tx_byte, // Last byte taken from host
    output logic tx_valid, // Pulse on host write
    output logic tx_sync, // Sync seen with write
    output logic [7:0] pkt_ready // Full packet per buffer
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Pin synchronisers, two flops each
    // ------------------------------------------------------------
    logic [14:0] sync1; // First stage, feeds only sync2
    logic [14:0] sync2; // Second stage, usable
    logic clk_d; // Previous synced port clock

    // Capture pins into the system clock domain
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 15'h0000;
            sync2 <= 15'h0000;
            clk_d <= 1'b0;
        end else begin
            sync1 <= {port_clock, data_in, buffer_select, read_write, access_enable, sync_in};
            sync2 <= sync1;
            clk_d <= sync2[14];
        end
    end

    // ------------------------------------------------------------
    // Decoded pin meaning after polarity
    // ------------------------------------------------------------
    // A polarity bit of zero keeps the pin active high, so reset gives the defaults
    wire port_rise = sync2[14] & ~clk_d;
    wire [7:0] s_data = sync2[13:6];
    wire [2:0] s_sel = sync2[5:3];
    wire is_read = sync2[2] ^ ctrl.rw_pol;
    wire enabled = sync2[1] ^ ctrl.en_pol;
    wire sync_act = sync2[0] ^ ctrl.sync_pol;
    wire [2:0] sel = ctrl.single_stream ? 3'h0 : s_sel;
    wire do_write = port_rise & enabled & ~is_read;
    wire do_read = port_rise & enabled & is_read;

    // ------------------------------------------------------------
    // Receive buffers: one array per buffer, written by link side
    // ------------------------------------------------------------
    logic [7:0] mem [NBUF][DEPTH]; // Receive storage
    logic [AW-1:0] wr_ptr [NBUF]; // Link write pointers
    logic [AW-1:0] rd_ptr [NBUF]; // Host read pointers
    logic [DEPTH-1:0] last_mark [NBUF]; // End of packet marks, one row per buffer
    logic [3:0] pkts [NBUF]; // Complete packets held

    genvar g;
    generate
        for (g = 0; g < NBUF; g++) begin : gen_buf
            wire push = rx_push & (rx_buf == 3'(g));
            wire pop = do_read & (sel == 3'(g)) & (pkts[g] != 4'h0);
            wire pop_last = pop & last_mark[g][rd_ptr[g]];
            // Store received bytes and track packet count
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    wr_ptr[g] <= '0;
                    rd_ptr[g] <= '0;
                    pkts[g] <= 4'h0;
                end else begin
                    if (push) begin
                        wr_ptr[g] <= wr_ptr[g] + 1'b1;
                    end
                    if (pop) begin
                        rd_ptr[g] <= rd_ptr[g] + 1'b1;
                    end
                    // A packet end arriving and one consumed in the same cycle cancel out
                    pkts[g] <= pkts[g] + 4'(push & rx_last) - 4'(pop_last);
                end
            end
            // Data store has no reset, saves area
            always_ff @(posedge clk) begin
                if (push) begin
                    mem[g][wr_ptr[g]] <= rx_byte;
                    last_mark[g][wr_ptr[g]] <= rx_last;
                end
            end
            assign pkt_ready[g] = (pkts[g] != 4'h0);
        end
    endgenerate

    // ------------------------------------------------------------
    // Host facing outputs, all from flops
    // ------------------------------------------------------------
    wire [7:0] rd_byte = mem[sel][rd_ptr[sel]];
    wire rd_first = (rd_ptr[sel] == '0) | last_mark[sel][rd_ptr[sel] - 1'b1];
    wire rd_mark = ctrl.sync_en & rd_first & pkt_ready[sel];

    // Drive data, sync, availability; capture host writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pins <= '0;
            tx_byte <= 8'h00;
            tx_valid <= 1'b0;
            tx_sync <= 1'b0;
        end else begin
            pins.data_oe <= enabled & is_read;
            pins.sync_oe <= ctrl.sync_en & enabled & is_read;
            pins.avail <= pkt_ready[sel] ^ ctrl.av_pol;
            if (do_read) begin
                pins.data_out <= rd_byte;
                pins.sync_out <= rd_mark ^ ctrl.sync_pol;
            end
            tx_valid <= do_write;
            if (do_write) begin
                tx_byte <= s_data;
                tx_sync <= ctrl.sync_en & sync_act;
            end
        end
    end
endmodule : stream_port_engine

// ----------------------------------------------------------------
// Top: two ports plus Avalon-MM register slave
// ----------------------------------------------------------------
module stream_data_ports
    import stream_port_pkg::*;
(
    input wire logic clk, // 200 MHz system clock
    input wire logic arst_n, // Async reset, active low
    input wire logic [7:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic port_a_clock, // Port A host clock
    input wire logic [7:0] port_a_data_bus_in, // Port A bus in
    output logic [7:0] port_a_data_bus_out, // Port A bus out
    output logic port_a_data_bus_oe, // Port A bus drive
    input wire logic [2:0] port_a_buffer_select, // Port A address
    input wire logic port_a_read_write, // Port A direction
    input wire logic port_a_access_enable, // Port A enable
    input wire logic port_a_packet_sync_in, // Port A sync in
    output logic port_a_packet_sync_out, // Port A sync out
    output logic port_a_packet_sync_oe, // Port A sync drive
    output logic port_a_data_available, // Port A available
    input wire logic port_b_clock, // Port B host clock
    input wire logic [7:0] port_b_data_bus_in, // Port B bus in
    output logic [7:0] port_b_data_bus_out, // Port B bus out
    output logic port_b_data_bus_oe, // Port B bus drive
    input wire logic [2:0] port_b_buffer_select, // Port B address
    input wire logic port_b_read_write, // Port B direction
    input wire logic port_b_access_enable, // Port B enable
    input wire logic port_b_packet_sync_in, // Port B sync in
    output logic port_b_packet_sync_out, // Port B sync out
    output logic port_b_packet_sync_oe, // Port B sync drive
    output logic port_b_data_available // Port B available
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    port_ctrl_t ctrl_a; // Port A configuration
    port_ctrl_t ctrl_b; // Port B configuration
    port_pins_out_t pins_a; // Port A pin drive
    port_pins_out_t pins_b; // Port B pin drive
    logic [7:0] tx_a, tx_b; // Host write bytes
    logic tv_a, tv_b; // Host write pulses
    logic ts_a, ts_b; // Host sync markers
    logic [7:0] rdy_a, rdy_b; // Packet ready per buffer
    logic [7:0] last_tx_a, last_tx_b; // Status copy of writes
    logic mark_a, mark_b; // Block mark seen with last write
    logic ack; // One cycle answer

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire req = (avs_read | avs_write) & ~ack;
    // Writes land only in the answer cycle, when waitrequest is low
    wire wr = avs_write & ack & avs_byteenable[0];
    wire sel_ca = avs_address == `REG_PORT_A_CTRL;
    wire sel_cb = avs_address == `REG_PORT_B_CTRL;
    wire sel_sa = avs_address == `REG_PORT_A_STATUS;
    wire sel_sb = avs_address == `REG_PORT_B_STATUS;
    wire sel_ra = avs_address == `REG_RX_ADD_A;
    wire sel_rb = avs_address == `REG_RX_ADD_B;
    wire push_a = wr & sel_ra;
    wire push_b = wr & sel_rb;
    // One wait cycle, then the answer; unmapped reads give zero
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    wire [31:0] rd_mux = sel_ca ? {26'h0, ctrl_a} :
                         sel_cb ? {26'h0, ctrl_b} :
                         sel_sa ? {15'h0, mark_a, last_tx_a, rdy_a} :
                         sel_sb ? {15'h0, mark_b, last_tx_b, rdy_b} : 32'h0000_0000;

    // Bus handshake and control writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            ctrl_a <= `CTRL_RESET;
            ctrl_b <= `CTRL_RESET;
        end else begin
            ack <= req;
            if (req & avs_read) begin
                avs_readdata <= rd_mux;
            end
            if (wr & sel_ca) begin
                ctrl_a <= avs_writedata[`CTRL_WIDTH-1:0];
            end
            if (wr & sel_cb) begin
                ctrl_b <= avs_writedata[`CTRL_WIDTH-1:0];
            end
        end
    end

    // Keep last host byte for software
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_tx_a <= 8'h00;
            last_tx_b <= 8'h00;
            mark_a <= 1'b0;
            mark_b <= 1'b0;
        end else begin
            if (tv_a) last_tx_a <= tx_a;
            if (tv_b) last_tx_b <= tx_b;
            if (tv_a) mark_a <= ts_a;
            if (tv_b) mark_b <= ts_b;
        end
    end

    // ------------------------------------------------------------
    // Two identical independent ports
    // ------------------------------------------------------------
    stream_port_engine u_port_a (
        .clk(clk), .arst_n(arst_n), .ctrl(ctrl_a),
        .port_clock(port_a_clock), .data_in(port_a_data_bus_in),
        .buffer_select(port_a_buffer_select), .read_write(port_a_read_write),
        .access_enable(port_a_access_enable), .sync_in(port_a_packet_sync_in),
        .rx_push(push_a), .rx_byte(avs_writedata[7:0]),
        .rx_buf(avs_writedata[10:8]), .rx_last(avs_writedata[11]),
        .pins(pins_a), .tx_byte(tx_a), .tx_valid(tv_a), .tx_sync(ts_a),
        .pkt_ready(rdy_a)
    );
    stream_port_engine u_port_b (
        .clk(clk), .arst_n(arst_n), .ctrl(ctrl_b),
        .port_clock(port_b_clock), .data_in(port_b_data_bus_in),
        .buffer_select(port_b_buffer_select), .read_write(port_b_read_write),
        .access_enable(port_b_access_enable), .sync_in(port_b_packet_sync_in),
        .rx_push(push_b), .rx_byte(avs_writedata[7:0]),
        .rx_buf(avs_writedata[10:8]), .rx_last(avs_writedata[11]),
        .pins(pins_b), .tx_byte(tx_b), .tx_valid(tv_b), .tx_sync(ts_b),
        .pkt_ready(rdy_b)
    );

    assign port_a_data_bus_out = pins_a.data_out;
    assign port_a_data_bus_oe = pins_a.data_oe;
    assign port_a_packet_sync_out = pins_a.sync_out;
    assign port_a_packet_sync_oe = pins_a.sync_oe;
    assign port_a_data_available = pins_a.avail;
    assign port_b_data_bus_out = pins_b.data_out;
    assign port_b_data_bus_oe = pins_b.data_oe;
    assign port_b_packet_sync_out = pins_b.sync_out;
    assign port_b_packet_sync_oe = pins_b.sync_oe;
    assign port_b_data_available = pins_b.avail;
endmodule : stream_data_ports

// [hw/stream_port_cfg.svh]
`ifndef STREAM_PORT_CFG_SVH
`define STREAM_PORT_CFG_SVH

// ----------------------------------------------------------------
// Register map (word aligned byte offsets)
// ----------------------------------------------------------------
`define REG_PORT_A_CTRL 8'h00
`define REG_PORT_B_CTRL 8'h04
`define REG_PORT_A_STATUS 8'h08
`define REG_PORT_B_STATUS 8'h0C
`define REG_RX_ADD_A 8'h10
`define REG_RX_ADD_B 8'h14

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define CTRL_SYNC_EN 0
`define CTRL_SYNC_POL 1
`define CTRL_RW_POL 2
`define CTRL_AV_POL 3
`define CTRL_EN_POL 4
`define CTRL_SINGLE 5
`define CTRL_WIDTH 6
`define CTRL_RESET 6'h00

// ----------------------------------------------------------------
// Timing and buffer sizes
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define MAX_BYTE_RATE_MBPS 27
`define BUF_COUNT 8
`define BUF_DEPTH 16

`endif

// [hw/stream_port_pkg.sv]
package stream_port_pkg;
    // Control register fields for one port
    typedef struct packed {
        logic single_stream;
        logic en_pol;
        logic av_pol;
        logic rw_pol;
        logic sync_pol;
        logic sync_en;
    } port_ctrl_t;

    // Pin group of one port, device view
    typedef struct packed {
        logic [7:0] data_out;
        logic data_oe;
        logic sync_out;
        logic sync_oe;
        logic avail;
    } port_pins_out_t;
endpackage : stream_port_pkg

// [tb/stream_data_ports_assertions.sv]
`timescale 1ns/1ps
// ----------------
// Checker on the register bus and the port pins
// ----------------
module stream_data_ports_assertions (
    input wire logic clk, // System clock
    input wire logic arst_n, // Reset, active low
    input wire logic [7:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic port_a_read_write, // A direction
    input wire logic port_a_access_enable, // A enable
    input wire logic port_a_data_bus_oe, // A bus drive
    input wire logic port_a_packet_sync_oe, // A sync drive
    input wire logic port_b_read_write, // B direction
    input wire logic port_b_access_enable, // B enable
    input wire logic port_b_data_bus_oe, // B bus drive
    input wire logic port_b_packet_sync_oe // B sync drive
);
    logic [3:0] age_a; // Cycles since an enabled read on A
    logic [3:0] age_b; // Same for B
    logic [1:0] sync_en; // Shadow of both sync enable bits
    wire wr_ok = avs_write && !avs_waitrequest; // Accepted write
    wire rd_a = port_a_access_enable && port_a_read_write; // Only default polarities
    wire rd_b = port_b_access_enable && port_b_read_write; // Only default polarities
    // Ages saturate; the pin synchronisers get a few cycles of slack
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            age_a <= 4'hF;
            age_b <= 4'hF;
        end else begin
            age_a <= rd_a ? 4'h0 : age_a + {3'h0, age_a != 4'hF};
            age_b <= rd_b ? 4'h0 : age_b + {3'h0, age_b != 4'hF};
        end
    end
    // Shadow follows accepted control writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_en <= 2'b00;
        end else if (wr_ok && avs_address[7:3] == 5'h00) begin
            sync_en[avs_address[2]] <= avs_writedata[0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----------------
    // Properties
    // ----------------
    sequence read_start;
        avs_read && !$past(avs_read);
    endsequence
    sequence one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_read_one_wait: assert property (read_start |-> one_wait)
        else $error("read not answered after one wait state");
    a_req_answered: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("request left waiting");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h14
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_drive_a_read: assert property (port_a_data_bus_oe |-> age_a <= 4'h6)
        else $error("port A bus driven outside a read");
    a_drive_b_read: assert property (port_b_data_bus_oe |-> age_b <= 4'h6)
        else $error("port B bus driven outside a read");
    a_sync_idle_a: assert property (!sync_en[0] |-> !port_a_packet_sync_oe)
        else $error("port A sync driven while unused");
    a_sync_idle_b: assert property (!sync_en[1] |-> !port_b_packet_sync_oe)
        else $error("port B sync driven while unused");
    a_reset_quiet: assert property ($rose(arst_n) |-> !port_a_data_bus_oe && !port_b_data_bus_oe)
        else $error("bus driven straight after reset");
endmodule : stream_data_ports_assertions

bind stream_data_ports stream_data_ports_assertions stream_data_ports_assertions_inst (
    .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .port_a_read_write, .port_a_access_enable, .port_a_data_bus_oe,
    .port_a_packet_sync_oe, .port_b_read_write, .port_b_access_enable, .port_b_data_bus_oe,
    .port_b_packet_sync_oe);

// [tb/stream_data_ports_bench.sv]
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
// ----------------
// Bench for the stream data ports
// ----------------
module stream_data_ports_bench;
    logic clk = 1'b0, arst_n = 1'b0; // Clock and reset
    logic [7:0] avs_address = 8'h00; // Register address
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest; // Handshake
    logic [31:0] avs_writedata = 32'h0, avs_readdata; // Data both ways
    logic port_a_clock, port_b_clock, port_a_data_bus_oe, port_b_data_bus_oe; // Clocks, drive
    logic [7:0] port_a_data_bus_in, port_b_data_bus_in, port_a_data_bus_out, port_b_data_bus_out;
    logic [2:0] port_a_buffer_select, port_b_buffer_select; // Buffer address
    logic port_a_read_write, port_b_read_write, port_a_access_enable, port_b_access_enable;
    logic port_a_packet_sync_in, port_b_packet_sync_in, port_a_packet_sync_out; // Sync
    logic port_b_packet_sync_out, port_a_packet_sync_oe, port_b_packet_sync_oe; // Sync
    logic port_a_data_available, port_b_data_available; // Packet flags
    int bad_count = 0, n_compared = 0, cycles = 0; // Tallies
    // Clock, and a hang limit far above the whole run
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            print_verdict();
        end
    end
    stream_data_ports stream_data_ports_inst (.clk, .arst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .port_a_clock, .port_a_data_bus_in, .port_a_data_bus_out, .port_a_data_bus_oe,
        .port_a_buffer_select, .port_a_read_write, .port_a_access_enable,
        .port_a_packet_sync_in, .port_a_packet_sync_out, .port_a_packet_sync_oe,
        .port_a_data_available, .port_b_clock, .port_b_data_bus_in, .port_b_data_bus_out,
        .port_b_data_bus_oe, .port_b_buffer_select, .port_b_read_write, .port_b_access_enable,
        .port_b_packet_sync_in, .port_b_packet_sync_out, .port_b_packet_sync_oe,
        .port_b_data_available);
    stream_host_model host_a (.clk, .dev_data(port_a_data_bus_out), .dev_oe(port_a_data_bus_oe),
        .dev_sync(port_a_packet_sync_out), .dev_sync_oe(port_a_packet_sync_oe),
        .port_clock(port_a_clock), .bus_level(port_a_data_bus_in),
        .buffer_select(port_a_buffer_select), .read_write(port_a_read_write),
        .access_enable(port_a_access_enable), .sync_level(port_a_packet_sync_in));
    stream_host_model host_b (.clk, .dev_data(port_b_data_bus_out), .dev_oe(port_b_data_bus_oe),
        .dev_sync(port_b_packet_sync_out), .dev_sync_oe(port_b_packet_sync_oe),
        .port_clock(port_b_clock), .bus_level(port_b_data_bus_in),
        .buffer_select(port_b_buffer_select), .read_write(port_b_read_write),
        .access_enable(port_b_access_enable), .sync_level(port_b_packet_sync_in));
    // Receive load word: byte, buffer, end-of-packet mark
    function automatic logic [31:0] rx_word(logic [7:0] b, logic [2:0] sel, logic last);
        return {20'h0, last, sel, b};
    endfunction : rx_word
    // Register cycle held until waitrequest is seen low, then released
    task automatic bus_cycle(input logic wr, input logic [7:0] a, input logic [31:0] d,
                             output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus_cycle
    task automatic check_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_cycle(1'b0, a, 32'h0, q);
        `CHECK_EQ(q, exp)
    endtask : check_rd
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_cycle(1'b1, a, d, q);
    endtask : wr_reg
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        logic [7:0] pkt [3];
        logic [7:0] b;
        logic [7:0] got;
        logic s;
        void'($urandom(32'hEEF10DC7));
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) check_rd(8'(4 * i), 32'h0);
        check_rd(8'h40, 32'h0);
        $display("Test reset values done");
        // Host writes on A, then B must stay separate
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            host_a.put_byte(3'(i), b, i == 0);
            check_rd(8'h08, {16'h0, b, 8'h00});
        end
        host_b.put_byte(3'h7, ~b, 1'b1);
        check_rd(8'h0C, {16'h0, ~b, 8'h00});
        check_rd(8'h08, {16'h0, b, 8'h00});
        $display("Test host writes done");
        // Packet into buffer 5; flag follows the selected buffer
        for (int i = 0; i < 3; i++) begin
            pkt[i] = 8'($urandom);
            wr_reg(8'h10, rx_word(pkt[i], 3'h5, i == 2));
        end
        host_a.select(3'h5);
        `CHECK_EQ(port_a_data_available, 1'b1)
        host_a.select(3'h2);
        `CHECK_EQ(port_a_data_available, 1'b0)
        check_rd(8'h08, {16'h0, b, 8'h20});
        for (int i = 0; i < 3; i++) begin
            host_a.get_byte(3'h5, got, s);
            `CHECK_EQ(got, pkt[i])
        end
        host_a.select(3'h5);
        `CHECK_EQ(port_a_data_available, 1'b0)
        $display("Test receive done");
        // Single stream ignores the address pins
        wr_reg(8'h00, 32'h20);
        check_rd(8'h00, 32'h20);
        pkt[0] = 8'($urandom);
        wr_reg(8'h10, rx_word(pkt[0], 3'h0, 1'b1));
        host_a.select(3'h6);
        `CHECK_EQ(port_a_data_available, 1'b1)
        host_a.get_byte(3'h6, got, s);
        `CHECK_EQ(got, pkt[0])
        $display("Test single stream done");
        // Sync on B marks the first byte, active high by default
        wr_reg(8'h04, 32'h1);
        for (int i = 0; i < 2; i++) begin
            pkt[i] = 8'($urandom);
            wr_reg(8'h14, rx_word(pkt[i], 3'h1, i == 1));
        end
        for (int i = 0; i < 2; i++) begin
            host_b.get_byte(3'h1, got, s);
            `CHECK_EQ(got, pkt[i])
            `CHECK_EQ(s, 1'(i == 0))
        end
        // Inverted available flag, then a host write carrying a block mark
        wr_reg(8'h04, 32'h9);
        host_b.select(3'h1);
        `CHECK_EQ(port_b_data_available, 1'b1)
        b = 8'($urandom);
        host_b.put_byte(3'h2, b, 1'b1);
        check_rd(8'h0C, {15'h0, 1'b1, b, 8'h00});
        $display("Test sync done");
        print_verdict();
    end
endmodule : stream_data_ports_bench

// [tb/stream_host_model.sv]
`timescale 1ns/1ps
// ----------------
// Host logic on one stream byte port
// ----------------
module stream_host_model (
    input wire logic clk, // System clock
    input wire logic [7:0] dev_data, // Device bus drive
    input wire logic dev_oe, // Device owns the bus
    input wire logic dev_sync, // Device sync drive
    input wire logic dev_sync_oe, // Device owns sync
    output logic port_clock, // Host port clock
    output logic [7:0] bus_level, // Resolved data bus
    output logic [2:0] buffer_select, // Buffer address
    output logic read_write, // High means read
    output logic access_enable, // Active high enable
    output logic sync_level // Resolved sync line
);
    logic [7:0] host_data = 8'h00; // Host bus drive
    logic host_drive = 1'b0; // Host owns the bus
    logic host_sync = 1'b0; // Host sync drive
    logic [7:0] idle_pat = 8'h5A; // Stand-in for a floating bus
    // No keeper: a released line must never echo the last byte
    always @(posedge clk) idle_pat <= ~idle_pat;
    assign bus_level = dev_oe ? dev_data : (host_drive ? host_data : idle_pat);
    assign sync_level = dev_sync_oe ? dev_sync : (host_drive ? host_sync : idle_pat[0]);
    initial begin
        port_clock = 1'b0;
        buffer_select = 3'h0;
        read_write = 1'b0;
        access_enable = 1'b0;
    end
    // One port clock period; the clock stands still between transfers
    task automatic pulse();
        repeat (16) @(posedge clk);
        port_clock <= 1'b1;
        repeat (16) @(posedge clk);
        port_clock <= 1'b0;
    endtask : pulse
    task automatic select(input logic [2:0] sel);
        buffer_select <= sel;
        repeat (16) @(posedge clk);
    endtask : select
    // Host write with optional block mark on sync
    task automatic put_byte(input logic [2:0] sel, input logic [7:0] b, input logic s);
        buffer_select <= sel;
        read_write <= 1'b0;
        access_enable <= 1'b1;
        host_data <= b;
        host_drive <= 1'b1;
        host_sync <= s;
        pulse();
        access_enable <= 1'b0;
        host_drive <= 1'b0;
        @(posedge clk);
    endtask : put_byte
    // Host read; bus and sync are taken just before the clock falls
    task automatic get_byte(input logic [2:0] sel, output logic [7:0] b, output logic s);
        buffer_select <= sel;
        read_write <= 1'b1;
        access_enable <= 1'b1;
        pulse();
        b = bus_level;
        s = sync_level;
        access_enable <= 1'b0;
        @(posedge clk);
    endtask : get_byte
endmodule : stream_host_model
